// >>> hdl/smc_consts.svh
// smc_consts.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from the controller module only
`ifndef SMC_CONSTS_SVH
`define SMC_CONSTS_SVH

// apb byte offsets of the control and status words
`define SMC_OFF_GLOBAL     12'h000
`define SMC_OFF_DEVCFG0    12'h010
`define SMC_OFF_STANDBY    12'h020
`define SMC_OFF_STATUS     12'h024
`define SMC_OFF_ACCESS     12'h028
`define SMC_OFF_LASTCMD    12'h02c

// global_config field positions
`define SMC_GC_INIT        0
`define SMC_GC_MRS         1
`define SMC_GC_LCR         2
// domain_device_config field positions
`define SMC_DC_WBS         0
`define SMC_DC_ROM         1
`define SMC_DC_BUS16       2
// reset values
`define SMC_GC_RST         32'h0000_0000
`define SMC_DC_RST         32'h0000_0000

// command word fields on the address pins
`define SMC_CMD_BL_LSB     0
`define SMC_CMD_BO_BIT     3
`define SMC_CMD_CAS_LSB    4
`define SMC_CMD_OM_LSB     7
`define SMC_CMD_WB_BIT     9

// timing
`define SMC_CLK_MHZ        25
`define SMC_FLASH_INIT_US  100
`define SMC_NOP_EXIT       10
`define SMC_NOP_ENTRY      2
`define SMC_STAB_CYC       16

`endif

// >>> hdl/smc_ctrl.sv
// smc_ctrl.sv: mode/config command words, self refresh, chip selects
// assumes: apb slave on clk, memory side on the same clock, no bus wait
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "smc_consts.svh"
module smc_ctrl
  import smc_pkg::*;
#(
  parameter int NUM_DOMAINS = 4,
  parameter int FLASH_INIT_CYC = `SMC_FLASH_INIT_US * `SMC_CLK_MHZ
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // processor side
  input  wire logic        boot_low_map_option,
  input  wire logic        standbyReq,
  input  wire logic        flashWpIn,
  output logic             standbyAck,
  // memory side
  output logic [12:0]      memAddr,
  output smc_cmd_t         memCmd,
  output logic [3:0]       domain_select_n,
  output logic             mem_clock_enable_out
);
  localparam int CW = 14;

  ////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0]      global_config_r;
  logic [31:0]      domain_device_config_r [NUM_DOMAINS];
  logic             bootLow_r;
  logic             bootSeen_r;
  logic [31:0]      accessAddr_r;
  logic [12:0]      lastCmd_r;
  logic [CW-1:0]    flashCnt_r;
  logic             flashReady_r;
  logic             wpPrev_r;
  smc_mode_dec_t    lastDec;
  logic [1:0]       dom;
  logic             domHit;
  logic             isMode;
  logic             isLoad;
  logic             wrEn;
  logic             rdEn;
  logic             accRd;

  assign wrEn = psel && penable && pwrite;
  assign rdEn = psel && penable && !pwrite;
  assign accRd = rdEn && (paddr == `SMC_OFF_ACCESS);
  assign pready = 1'b1;                 // zero-wait slave
  assign pslverr = 1'b0;

  // global and per-domain configuration writes
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      global_config_r <= `SMC_GC_RST;
    end else if (wrEn && paddr == `SMC_OFF_GLOBAL) begin
      global_config_r <= {29'h0, pwdata[2:0]};
    end
  end

  // one config word per domain, each its own type and bus width
  genvar g;
  generate
    for (g = 0; g < NUM_DOMAINS; g++) begin : gDom
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          domain_device_config_r[g] <= `SMC_DC_RST;
        end else if (wrEn && paddr == 12'(`SMC_OFF_DEVCFG0 + 4 * g)) begin
          domain_device_config_r[g] <= {29'h0, pwdata[2:0]};
        end
      end
    end
  endgenerate

  // boot strap caught on the first clock after reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bootLow_r  <= 1'b0;
      bootSeen_r <= 1'b0;
    end else if (!bootSeen_r) begin
      bootLow_r  <= boot_low_map_option;
      bootSeen_r <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // chip select decode from the access address top nibble
  always_comb begin
    dom = 2'h0;
    domHit = 1'b1;
    case (accessAddr_r[31:28])
      4'he:    dom = 2'h2;
      4'hd:    dom = 2'h1;
      4'hc:    dom = 2'h0;
      4'h0:    begin dom = 2'h3; domHit = bootLow_r; end
      4'hf:    begin dom = 2'h3; domHit = !bootLow_r; end
      default: domHit = 1'b0;
    endcase
  end

  // software places the target address then reads the access word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accessAddr_r <= 32'h0;
    end else if (wrEn && paddr == `SMC_OFF_ACCESS) begin
      accessAddr_r <= pwdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode or load command on a read, chosen by global config, load only when the target domain is flash (wbs set)
  assign isMode = !global_config_r[`SMC_GC_INIT] &&
                  global_config_r[`SMC_GC_MRS] &&
                  !global_config_r[`SMC_GC_LCR];
  assign isLoad = global_config_r[`SMC_GC_LCR] &&
                  domain_device_config_r[dom][`SMC_DC_WBS];

  // address bits chosen per bus width: a22..a10 or a21..a9 window
  function automatic logic [12:0] cmdWord(input logic [31:0] a,
                                          input logic        bus16);
    cmdWord = bus16 ? a[21:9] : a[22:10];
  endfunction

  smc_mode_decode uDec (
    .word    (smc_mode_word_t'(lastCmd_r)),
    .isRom   (domain_device_config_r[dom][`SMC_DC_ROM]),
    .isFlash (domain_device_config_r[dom][`SMC_DC_WBS]),
    .dec     (lastDec)
  );

  ////////////////////////////////////////////////////////////////////////
  // flash write-protect init timer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wpPrev_r     <= 1'b0;
      flashCnt_r   <= '0;
      flashReady_r <= 1'b0;
    end else begin
      wpPrev_r <= flashWpIn;
      if (!flashWpIn) begin
        flashReady_r <= 1'b0;
        flashCnt_r   <= '0;
      end else if (!wpPrev_r) begin
        flashCnt_r   <= CW'(FLASH_INIT_CYC - 1);
      end else if (flashCnt_r != '0) begin
        flashCnt_r   <= flashCnt_r - 1'b1;
      end else begin
        flashReady_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // standby sequencer
  typedef enum logic [8:0] {
    ST_RUN   = 9'h001,
    ST_PALL  = 9'h002,
    ST_ENOP  = 9'h004,
    ST_CKLO  = 9'h008,
    ST_AREF  = 9'h010,
    ST_SREF  = 9'h020,
    ST_STAB  = 9'h040,
    ST_XNOP  = 9'h080,
    ST_XREF  = 9'h100
  } smc_state_t;
  smc_state_t state_r;
  smc_state_t state_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt = (cnt_r != 5'h0) ? cnt_r - 5'h1 : 5'h0;
    case (state_r)
      ST_RUN:  if (standbyReq) state_nxt = ST_PALL;
      ST_PALL: begin
        state_nxt = ST_ENOP;
        cnt_nxt = 5'(`SMC_NOP_ENTRY - 1);
      end
      ST_ENOP: if (cnt_r == 5'h0) state_nxt = ST_CKLO;
      ST_CKLO: state_nxt = ST_AREF;
      ST_AREF: state_nxt = ST_SREF;
      ST_SREF: if (!standbyReq) begin
        state_nxt = ST_STAB;
        cnt_nxt = 5'(`SMC_STAB_CYC - 1);
      end
      ST_STAB: if (cnt_r == 5'h0) begin
        state_nxt = ST_XNOP;
        cnt_nxt = 5'(`SMC_NOP_EXIT - 1);
      end
      ST_XNOP: if (cnt_r == 5'h0) state_nxt = ST_XREF;
      ST_XREF: state_nxt = ST_RUN;
      default: state_nxt = ST_RUN;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RUN;
      cnt_r   <= 5'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  // clock enable falls before entry refresh, rises at the end of stab
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_clock_enable_out <= 1'b1;
    end else if (state_nxt == ST_CKLO) begin
      mem_clock_enable_out <= 1'b0;
    end else if (state_nxt == ST_XNOP) begin
      mem_clock_enable_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory command, address and chip select outputs
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      memCmd          <= SMC_CMD_NOP;
      memAddr         <= 13'h0;
      domain_select_n <= 4'hf;
      lastCmd_r       <= 13'h0;
    end else begin
      memCmd          <= SMC_CMD_NOP;
      domain_select_n <= 4'hf;
      case (state_nxt)
        ST_PALL: begin
          memCmd <= SMC_CMD_PALL;
          domain_select_n <= 4'h0;
        end
        ST_AREF, ST_XREF: begin
          // flash domains never see an auto refresh; self refresh entry and exit select all domains
          memCmd <= SMC_CMD_AREF;
          for (int i = 0; i < NUM_DOMAINS; i++) begin
            domain_select_n[i] <=
              domain_device_config_r[i][`SMC_DC_WBS];
          end
        end
        ST_SREF: if (state_r == ST_AREF) begin
          memCmd <= SMC_CMD_SREF;
          domain_select_n <= 4'h0;
        end
        ST_RUN: if (state_r == ST_XREF) begin
          memCmd <= SMC_CMD_SRX;
          domain_select_n <= 4'h0;
        end else if (accRd && domHit &&
                     (!domain_device_config_r[dom][`SMC_DC_WBS] ||
                      flashReady_r)) begin
          memAddr <= cmdWord(accessAddr_r,
                             domain_device_config_r[dom][`SMC_DC_BUS16]);
          domain_select_n[dom] <= 1'b0;
          if (isMode) begin
            memCmd    <= SMC_CMD_MODE;
            lastCmd_r <= cmdWord(accessAddr_r,
                         domain_device_config_r[dom][`SMC_DC_BUS16]);
          end else if (isLoad) begin
            memCmd <= SMC_CMD_LOAD;
          end else begin
            memCmd <= SMC_CMD_READ;
          end
        end
        default: ;
      endcase
    end
  end

  assign standbyAck = (state_r == ST_SREF);

  ////////////////////////////////////////////////////////////////////////
  // read mux; unmapped offsets read zero
  always_comb begin
    prdata = 32'h0;
    case (paddr)
      `SMC_OFF_GLOBAL:  prdata = global_config_r;
      `SMC_OFF_ACCESS:  prdata = accessAddr_r;
      `SMC_OFF_LASTCMD: prdata = {19'h0, lastCmd_r};
      `SMC_OFF_STATUS:  prdata = {lastDec.burstLen, lastDec.casLatency,
                                  lastDec.rasClocks, lastDec.interleaved,
                                  lastDec.singleWrite, lastDec.valid,
                                  flashReady_r, bootLow_r,
                                  mem_clock_enable_out, standbyAck, 14'h0,
                                  state_r == ST_RUN};
      default: begin
        for (int i = 0; i < NUM_DOMAINS; i++) begin
          if (paddr == 12'(`SMC_OFF_DEVCFG0 + 4 * i)) begin
            prdata = domain_device_config_r[i];
          end
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// >>> hdl/smc_mode_decode.sv
// smc_mode_decode.sv: decodes a mode command word per device type
// assumes: purely combinational, used by smc_ctrl
`timescale 1ns/10ps
`default_nettype none
module smc_mode_decode
  import smc_pkg::*;
(
  // command word and device type
  input  wire smc_mode_word_t word,
  input  wire logic           isRom,
  input  wire logic           isFlash,
  // decoded result
  output smc_mode_dec_t       dec
);
  // per-type tables; reserved codes clear valid
  always_comb begin
    dec = '0;
    dec.interleaved = word.burstOrder;
    if (isRom) begin
      // rom burst length from two low bits only
      case (word.burstLenCode[1:0])
        2'h1:    dec.burstLen = 4'h4;
        2'h2:    dec.burstLen = 4'h8;
        default: dec.burstLen = 4'h0;
      endcase
      // cas 001..111 maps to two..eight, 000 reserved
      dec.casLatency = (word.casLatencyCode == 3'h0) ? 4'h0 :
                       4'({1'b0, word.casLatencyCode} + 4'h1);
      // ras field sits in bit 7 of the rom layout
      dec.rasClocks = word.operatingModeCode[0] ? 2'h2 : 2'h1;
      dec.singleWrite = 1'b0;
    end else if (isFlash) begin
      case (word.burstLenCode)
        3'h0:    dec.burstLen = 4'h1;
        3'h1:    dec.burstLen = 4'h2;
        3'h2:    dec.burstLen = 4'h4;
        3'h3:    dec.burstLen = 4'h8;
        default: dec.burstLen = 4'h0;
      endcase
      dec.casLatency = (word.casLatencyCode <= 3'h3) ?
                       {1'b0, word.casLatencyCode} : 4'h0;
      dec.singleWrite = word.writeBurstSelect;
    end else begin
      case (word.burstLenCode)
        3'h2:    dec.burstLen = 4'h4;
        3'h3:    dec.burstLen = 4'h8;
        default: dec.burstLen = 4'h0;
      endcase
      // only latency two and three exist for sdram
      case (word.casLatencyCode)
        3'h2:    dec.casLatency = 4'h2;
        3'h3:    dec.casLatency = 4'h3;
        default: dec.casLatency = 4'h0;
      endcase
      dec.singleWrite = word.writeBurstSelect;
    end
    dec.valid = (dec.burstLen != 4'h0) && (dec.casLatency != 4'h0);
  end
endmodule
`default_nettype wire

// >>> hdl/smc_pkg.sv
// smc_pkg.sv: types shared by the memory-controller slice
// assumes: constants come from smc_consts.svh
package smc_pkg;
  // memory command put on the ras/cas/we pins
  typedef enum logic [2:0] {
    SMC_CMD_NOP  = 3'h0,
    SMC_CMD_PALL = 3'h1,
    SMC_CMD_AREF = 3'h2,
    SMC_CMD_SREF = 3'h3,
    SMC_CMD_SRX  = 3'h4,
    SMC_CMD_MODE = 3'h5,
    SMC_CMD_LOAD = 3'h6,
    SMC_CMD_READ = 3'h7
  } smc_cmd_t;

  // decoded mode command word fields
  typedef struct packed {
    logic [2:0] resv;
    logic       writeBurstSelect;
    logic [1:0] operatingModeCode;
    logic [2:0] casLatencyCode;
    logic       burstOrder;
    logic [2:0] burstLenCode;
  } smc_mode_word_t;

  // decoded timing of one command word
  typedef struct packed {
    logic [3:0] burstLen;
    logic [3:0] casLatency;
    logic [1:0] rasClocks;
    logic       interleaved;
    logic       singleWrite;
    logic       valid;
  } smc_mode_dec_t;
endpackage

// >>> tb/smc_ctrl_props.sv
// smc_ctrl_props.sv: port-level checks for smc_ctrl
// assumes: bound to smc_ctrl, one clock, strap only moves in reset
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl_props
  import smc_pkg::*;
(
  // apb side
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // processor and memory side
  input wire logic        boot_low_map_option,
  input wire logic        standbyReq,
  input wire logic        standbyAck,
  input wire smc_cmd_t    memCmd,
  input wire logic [3:0]  domain_select_n,
  input wire logic        mem_clock_enable_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  //////////////////////////////////////////////////////////////////////////////
  // shadow of the setup, taken off apb writes so checks need no hierarchy
  logic [31:0] tgt_r;
  logic [2:0]  glob_r;
  logic [3:0]  wbs_r;
  wire         wr    = psel && penable && pwrite;
  wire         rdAcc = psel && penable && !pwrite && paddr == 12'h028;
  wire         isAcc = memCmd inside {SMC_CMD_MODE, SMC_CMD_LOAD, SMC_CMD_READ};
  wire  [3:0]  csExp;
  assign csExp = (tgt_r[31:28] == 4'hc) ? 4'he :
                 (tgt_r[31:28] == 4'hd) ? 4'hd :
                 (tgt_r[31:28] == 4'he) ? 4'hb :
                 (tgt_r[31:28] == {4{!boot_low_map_option}}) ? 4'h7 : 4'hf;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tgt_r  <= 32'h0;
      glob_r <= 3'h0;
      wbs_r  <= 4'h0;
    end else if (wr) begin
      if (paddr == 12'h028) tgt_r <= pwdata;
      if (paddr == 12'h000) glob_r <= pwdata[2:0];
      if (paddr[11:4] == 8'h01) wbs_r[paddr[3:2]] <= pwdata[0];
    end
  end
  sequence sTwoNop;
    (memCmd == SMC_CMD_NOP) [*2];
  endsequence
  sequence sTenNop;
    (memCmd == SMC_CMD_NOP) [*8] ##1 sTwoNop;
  endsequence
  a_apb_no_wait: assert property (
    psel && penable |-> pready && !pslverr) else $error("apb stalled");
  a_mode_cfg: assert property (
    memCmd == SMC_CMD_MODE |-> glob_r == 3'b010) else $error("stray mode");
  a_cmd_after_read: assert property (
    isAcc |-> $past(rdAcc)) else $error("command without read");
  a_load_flash: assert property (
    memCmd == SMC_CMD_LOAD |-> glob_r[2] && (~domain_select_n & ~wbs_r) == 4'h0)
    else $error("stray load");
  a_cs_decode: assert property (
    isAcc |-> domain_select_n == csExp) else $error("wrong select");
  a_miss_nop: assert property (
    $past(rdAcc) && csExp == 4'hf |-> memCmd == SMC_CMD_NOP)
    else $error("command on miss");
  a_idle_cs: assert property (
    memCmd == SMC_CMD_NOP |-> domain_select_n == 4'hf) else $error("idle cs");
  a_pall_cs: assert property (
    memCmd == SMC_CMD_PALL |-> domain_select_n == 4'h0) else $error("pall cs");
  a_aref_dom: assert property (
    memCmd == SMC_CMD_AREF |-> domain_select_n == wbs_r)
    else $error("refresh reached flash");
  a_entry_order: assert property (
    memCmd == SMC_CMD_PALL |-> ##1 sTwoNop ##[0:2]
    (memCmd == SMC_CMD_AREF && !mem_clock_enable_out) ##[1:2]
    memCmd == SMC_CMD_SREF) else $error("entry order");
  a_stab_wait: assert property (
    $fell(standbyReq) && standbyAck |-> (!mem_clock_enable_out) [*8])
    else $error("no stabilise wait");
  a_exit_order: assert property (
    $rose(mem_clock_enable_out) |-> sTenNop ##[1:2]
    memCmd == SMC_CMD_AREF ##[1:2] memCmd == SMC_CMD_SRX)
    else $error("exit order");
  a_ack_cke_low: assert property (
    $rose(standbyAck) |-> !mem_clock_enable_out) else $error("ack with cke");
endmodule
`default_nettype wire

// >>> tb/smc_ctrl_tb_top.sv
// smc_ctrl_tb_top.sv: self-checking bench for the memory controller slice
// assumes: smc_ctrl, smc_mem_model and smc_ctrl_props compiled before it
`timescale 1ns/10ps
`default_nettype none
module smc_ctrl_tb_top
  import smc_pkg::*;
;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        boot_low_map_option, standbyReq, flashWpIn, standbyAck;
  logic        mem_clock_enable_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [12:0] memAddr, modeWord;
  smc_cmd_t    memCmd, lastCmd;
  logic [3:0]  domain_select_n, arefCs;
  logic [7:0]  exitNops, badCnt;
  int          failures, compares;
  // flash wait shortened to 8 cycles to keep the run brief
  smc_ctrl #(.FLASH_INIT_CYC(8)) u_smc_ctrl (
    .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .boot_low_map_option, .standbyReq, .flashWpIn,
    .standbyAck, .memAddr, .memCmd, .domain_select_n, .mem_clock_enable_out
  );
  smc_mem_model u_smc_mem_model (
    .clk, .rst_n, .memAddr, .memCmd, .domain_select_n,
    .mem_clock_enable_out, .modeWord, .lastCmd, .arefCs, .exitNops, .badCnt
  );
  always #20 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  // expectations and bus tasks
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic [3:0] csOf(input logic [3:0] n, input logic s);
    case (n)
      4'hc: return 4'he;
      4'hd: return 4'hd;
      4'he: return 4'hb;
      4'h0: return s ? 4'h7 : 4'hf;
      4'hf: return s ? 4'hf : 4'h7;
      default: return 4'hf;
    endcase
  endfunction
  // ras is only meaningful for rom and single write only for the others
  function automatic void expDec(input logic [12:0] w, input int ty,
                                 output logic [31:0] e, output logic [31:0] m);
    logic [3:0] bl, cs;
    logic       v;
    if (ty == 2) begin
      bl = (w[1:0] == 2'h1) ? 4'h4 : (w[1:0] == 2'h2) ? 4'h8 : 4'h0;
      cs = (w[6:4] == 3'h0) ? 4'h0 : {1'b0, w[6:4]} + 4'h1;
    end else if (ty == 1) begin
      bl = w[2] ? 4'h0 : 4'h1 << w[1:0];
      cs = (w[6:4] inside {3'h1, 3'h2, 3'h3}) ? {1'b0, w[6:4]} : 4'h0;
    end else begin
      bl = (w[2:0] == 3'h2) ? 4'h4 : (w[2:0] == 3'h3) ? 4'h8 : 4'h0;
      cs = (w[6:4] inside {3'h2, 3'h3}) ? {1'b0, w[6:4]} : 4'h0;
    end
    v = bl != 4'h0 && cs != 4'h0;
    e = {bl, cs, w[7], !w[7], w[3], w[9] && ty != 2, v, 19'h0};
    m = {{8{v}}, {2{v && ty == 2}}, v, v && ty != 2, 1'b1, 19'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkCmd(input string nm, input smc_cmd_t e, input smc_cmd_t g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %s seen %s", nm, e.name(), g.name());
    end
  endtask
  // one apb transfer: setup, then access held until pready at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // the command is launched at the read's access edge and stands one cycle,
  // so it is looked at just after that edge, not one edge later
  task automatic issue(input logic [31:0] t);
    apb(1'b1, 12'h028, t);
    apb(1'b0, 12'h028, 32'h0);
    #1;
  endtask
  task automatic sweep(input logic s);
    logic [3:0] nib [6] = '{4'h0, 4'h5, 4'hc, 4'hd, 4'he, 4'hf};
    foreach (nib[k]) begin
      issue({nib[k], 28'h0012_3400});
      chk("select", csOf(nib[k], s), domain_select_n);
      chkCmd("read", (csOf(nib[k], s) == 4'hf) ? SMC_CMD_NOP : SMC_CMD_READ,
             memCmd);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int          ty;
    logic        b16;
    logic [3:0]  dom;
    logic [12:0] w;
    logic [31:0] t, e, m;
    logic [31:0] offs [6] = '{32'h0000_c800, 32'h0008_c800, 32'h0001_8400,
                              32'h0000_6600, 32'h0004_6600, 32'h0000_c400};
    {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {boot_low_map_option, standbyReq, flashWpIn} = '0;
    failures = 0;
    compares = 0;
    seed = 32'h011dbbea;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk("reset cke", 1'b1, mem_clock_enable_out);
    chk("reset selects", 4'hf, domain_select_n);
    apb(1'b0, 12'h000, 32'h0);
    chk("global reset", 32'h0, rd);
    apb(1'b1, 12'h100, 32'h5);
    apb(1'b0, 12'h100, 32'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h000, 32'h2);
    issue(32'hc000_c800);
    chkCmd("early flash", SMC_CMD_NOP, memCmd);
    flashWpIn <= 1'b1;
    repeat (12) @(posedge clk);
    // fixed offsets first, then random words within the legal fields
    for (int i = 0; i < 30; i++) begin
      seed = xs(seed);
      ty = (i < 6) ? i % 3 : seed[1:0] % 3;
      b16 = (i < 6) ? i >= 3 : seed[2];
      w = seed[15:3] & ((ty == 2) ? 13'h0ff : 13'h27f);
      t = b16 ? {10'h0, w, 9'h0} : {9'h0, w, 10'h0};
      if (i < 6) t = offs[i];
      dom = i % 3;
      t[31:28] = 4'hc + dom;
      w = b16 ? t[21:9] : t[22:10];
      apb(1'b1, 12'h010 + {dom, 2'b0}, {29'h0, b16, ty == 2, ty == 1});
      issue(t);
      chkCmd("mode cmd", SMC_CMD_MODE, memCmd);
      chk("mode word", w, memAddr);
      chk("mode select", csOf(t[31:28], 1'b0), domain_select_n);
      apb(1'b0, 12'h024, 32'h0);
      chk("model word", w, modeWord);
      expDec(w, ty, e, m);
      chk("decode", e & m, rd & m);
    end
    apb(1'b1, 12'h000, 32'h4);
    apb(1'b1, 12'h010, 32'h1);
    apb(1'b1, 12'h014, 32'h0);
    t = {4'hc, seed[27:0]};
    issue(t);
    chkCmd("load cmd", SMC_CMD_LOAD, memCmd);
    issue({4'hd, seed[27:0]});
    chkCmd("plain read", SMC_CMD_READ, memCmd);
    chk("load word", t[22:10], modeWord);
    apb(1'b1, 12'h000, 32'h0);
    sweep(1'b0);
    rst_n <= 1'b0;
    boot_low_map_option <= 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    sweep(1'b1);
    apb(1'b1, 12'h010, 32'h1);
    standbyReq <= 1'b1;
    for (int n = 0; n < 60 && standbyAck !== 1'b1; n++) @(posedge clk);
    #1;
    chk("ack", 1'b1, standbyAck);
    chk("cke low", 1'b0, mem_clock_enable_out);
    chk("refresh selects", 4'h1, arefCs);
    standbyReq <= 1'b0;
    for (int n = 0; n < 80 && lastCmd !== SMC_CMD_SRX; n++) @(posedge clk);
    #1;
    chkCmd("exit", SMC_CMD_SRX, lastCmd);
    chk("cke high", 1'b1, mem_clock_enable_out);
    chk("exit nops", 1'b1, exitNops >= 8'd10);
    chk("cke misuse", 8'h0, badCnt);
    report_and_stop();
  end
endmodule
bind smc_ctrl smc_ctrl_props u_smc_ctrl_props (
  .clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .boot_low_map_option, .standbyReq, .standbyAck, .memCmd,
  .domain_select_n, .mem_clock_enable_out
);
`default_nettype wire

// >>> tb/smc_mem_model.sv
// smc_mem_model.sv: observing model of the synchronous memories
// assumes: sees the controller's memory pins on the same clock
`timescale 1ns/10ps
`default_nettype none
module smc_mem_model
  import smc_pkg::*;
(
  // memory pins
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [12:0] memAddr,
  input  wire smc_cmd_t    memCmd,
  input  wire logic [3:0]  domain_select_n,
  input  wire logic        mem_clock_enable_out,
  // what the devices have seen
  output logic [12:0]      modeWord,
  output smc_cmd_t         lastCmd,
  output logic [3:0]       arefCs,
  output logic [7:0]       exitNops,
  output logic [7:0]       badCnt
);
  logic       ckeOld;
  logic [7:0] nopRun;
  //////////////////////////////////////////////////////////////////////////////
  // devices latch the address pins as a command word on mode or load
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      modeWord <= 13'h0;
      lastCmd  <= SMC_CMD_NOP;
      arefCs   <= 4'hf;
    end else if (memCmd != SMC_CMD_NOP) begin
      lastCmd <= memCmd;
      if (memCmd inside {SMC_CMD_MODE, SMC_CMD_LOAD}) modeWord <= memAddr;
      if (memCmd == SMC_CMD_AREF) arefCs <= domain_select_n;
    end
  end
  // nops counted from the rise of clock enable, rise cycle included, so
  // either reading of where the ten start still gives ten or more
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ckeOld   <= 1'b1;
      nopRun   <= 8'h0;
      exitNops <= 8'h0;
      badCnt   <= 8'h0;
    end else begin
      ckeOld <= mem_clock_enable_out;
      if (mem_clock_enable_out && !ckeOld) begin
        nopRun <= {7'h0, memCmd == SMC_CMD_NOP};
      end else if (memCmd == SMC_CMD_NOP && nopRun != 8'hff) begin
        nopRun <= nopRun + 8'h1;
      end
      if (memCmd == SMC_CMD_AREF) exitNops <= nopRun;
      if (!mem_clock_enable_out && memCmd inside {SMC_CMD_PALL, SMC_CMD_MODE,
          SMC_CMD_LOAD, SMC_CMD_READ}) badCnt <= badCnt + 8'h1;
    end
  end
endmodule
`default_nettype wire
